// ---- inc/sfwp_pkg.sv ----
`default_nettype none
package sfwp_pkg;
   // command opcodes
   localparam logic [7:0] CMD_WRITE_ENABLE_CMD_C = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE_CMD_C = 8'h04;
   localparam logic [7:0] CMD_RDSR_C = 8'h05;
   localparam logic [7:0] CMD_STATUS_WRITE_CMD_C = 8'h01;
   localparam logic [7:0] CMD_PAGE_C = 8'h02;
   localparam logic [7:0] CMD_SECT_C = 8'h20;
   localparam logic [7:0] CMD_B32_C = 8'h52;
   localparam logic [7:0] CMD_B64_C = 8'hD8;
   localparam logic [7:0] CMD_CE1_C = 8'h60;
   localparam logic [7:0] CMD_CE2_C = 8'hC7;
   localparam logic [7:0] CMD_DP_C = 8'hB9;
   localparam logic [7:0] CMD_RDP_C = 8'hAB;
   // status bit positions
   localparam int SB_LOCKSEL = 7;
   localparam int SB_SEC = 6;
   localparam int SB_CMP = 5;
   localparam int SB_LVL_HI = 4;
   localparam int SB_LVL_LO = 2;
   localparam int SB_WEL = 1;
   localparam int SB_BUSY = 0;
   localparam logic [7:0] STATUS_RST = 8'h00;
   // array
   localparam int ADDR_W = 24;
   localparam logic [23:0] ARRAY_TOP = 24'h0FFFFF;
   localparam logic [2:0] LVL_NONE = 3'h0;
   localparam logic [2:0] LVL_ALL = 3'h7;
   localparam int BITS_BYTE = 8;
   localparam logic [5:0] BITS_CMD = 6'h08;
   localparam logic [5:0] BITS_STAT = 6'h10;
   localparam logic [5:0] BITS_ADDR = 6'h20;
   // busy time in system-clock cycles
   localparam logic [15:0] BUSY_CYC_DEF = 16'h0040;
endpackage
`default_nettype wire

// ---- src/sfwp_core.sv ----
`default_nettype none
// Summary of operation
// - a complete write-enable command sets the write latch
// - write latch clears on reset, write-disable, finished status write/program/erase
// - in deep power-down only the release command is obeyed
// - status is eight bits: lock select, security, complement, level, latch, busy
// - busy reads 1 while a program, erase or status write runs
// - latch at 0 refuses status write, program and erase
// - protect level is non-volatile, changed only by status write
// - page program, sector and block wipe in protected region are refused
// - complement 0: levels decode to bottom protected ranges
// - complement 1: levels decode to top protected ranges
// - protect level writable only outside hardware-protected mode
// - chip erase only with level 0/complement 0 or level 7/complement 1
// - lock select 0: status write accepted whenever latch is 1 and busy is 0
// - lock select 1 with protect pin low: status writes refused
// - lock select 1 with protect pin high: status write accepted if latched
// - complement bit is non-volatile read/write, default 0
// - write-type commands end on a byte boundary or are refused
// - write-disable ignored while busy
module sfwp_core
   import sfwp_pkg::*;
#(
   parameter logic [15:0] BUSY_CYC = BUSY_CYC_DEF
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic wp_n,
   output logic spi_so,
   output logic spi_so_oe_n,
   output logic [7:0] status_out,
   output logic deep_pd,
   output logic op_start,
   output logic [1:0] op_kind,
   output logic [23:0] op_addr
);
   //----------------------------------------
   // reset and input synchronisers
   //----------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [1:0] sclk_s_q, cs_s_q, si_s_q, wp_s_q;
   logic sclk_d1_q;
   // reset release through two flops
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // pin synchronisers, cs idles high
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s_q <= 2'h0;
         cs_s_q <= 2'h3;
         si_s_q <= 2'h0;
         wp_s_q <= 2'h3;
         sclk_d1_q <= 1'b0;
      end else begin
         sclk_s_q <= {sclk_s_q[0], spi_sclk};
         cs_s_q <= {cs_s_q[0], spi_cs_n};
         si_s_q <= {si_s_q[0], spi_si};
         wp_s_q <= {wp_s_q[0], wp_n};
         sclk_d1_q <= sclk_s_q[1];
      end
   end

   //----------------------------------------
   // edge and frame decode
   //----------------------------------------
   logic sclk_rise, sclk_fall, cs_n_s, cs_d1_q, frame_end;
   assign cs_n_s = cs_s_q[1];
   assign sclk_rise = sclk_s_q[1] & ~sclk_d1_q & ~cs_n_s;
   assign sclk_fall = ~sclk_s_q[1] & sclk_d1_q & ~cs_n_s;
   assign frame_end = cs_n_s & ~cs_d1_q;

   //----------------------------------------
   // shifter
   //----------------------------------------
   logic [5:0] bitcnt_q;
   logic [7:0] cmd_q, sr_data_q, shift_q;
   logic [23:0] addr_q;
   logic byte_ok;
   // bit count wraps from 63 back to 56 so long frames stay aligned check-able
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_d1_q <= 1'b1;
         bitcnt_q <= 6'h00;
         shift_q <= 8'h00;
         cmd_q <= 8'h00;
         sr_data_q <= 8'h00;
         addr_q <= 24'h000000;
      end else begin
         cs_d1_q <= cs_n_s;
         if (cs_n_s) bitcnt_q <= 6'h00;
         else if (sclk_rise) begin
            bitcnt_q <= (bitcnt_q == 6'h3F) ? 6'h38 : bitcnt_q + 6'h01;
            shift_q <= {shift_q[6:0], si_s_q[1]};
            if (bitcnt_q == BITS_CMD - 6'h01)
               cmd_q <= {shift_q[6:0], si_s_q[1]};
            if (bitcnt_q == BITS_STAT - 6'h01)
               sr_data_q <= {shift_q[6:0], si_s_q[1]};
            if (bitcnt_q >= BITS_CMD && bitcnt_q < BITS_ADDR)
               addr_q <= {addr_q[22:0], si_s_q[1]};
         end
      end
   end
   // byte boundary check at frame end
   assign byte_ok = (bitcnt_q[2:0] == 3'h0);

   //----------------------------------------
   // status state
   //----------------------------------------
   logic lock_sel_q, sec_q, cmp_q, wel_q, busy_q, dp_q;
   logic [2:0] lvl_q;
   logic [15:0] busy_cnt_q;
   logic [7:0] status;
   // status layout
   assign status = {lock_sel_q, sec_q, cmp_q, lvl_q, wel_q, busy_q};

   // protected-range
   function automatic logic in_prot(input logic [2:0] lvl,
                                    input logic cmp,
                                    input logic [23:0] a);
      logic [23:0] span;
      logic hit;
      span = (ARRAY_TOP + 24'h000001) >> (4'h8 - {1'b0, lvl});
      if (!cmp) begin
         if (lvl == LVL_NONE) hit = 1'b0;
         else if (lvl == LVL_ALL) hit = 1'b1;
         else hit = (a < (ARRAY_TOP + 24'h000001 - span));
      end else begin
         if (lvl == LVL_NONE) hit = 1'b1;
         else if (lvl == LVL_ALL) hit = 1'b0;
         else hit = (a >= (ARRAY_TOP + 24'h000001 - span));
      end
      return hit & (a <= ARRAY_TOP);
   endfunction
   // note: span of level n is 2^(n+12) bytes of the 1 MiB top region

   //----------------------------------------
   // command decode
   //----------------------------------------
   logic is_write_enable_cmd, is_write_disable_cmd, is_status_write_cmd, is_page, is_wipe, is_chip;
   logic is_dp, is_rdp, ended, sr_wr_allowed, prot_hit, chip_ok;
   logic do_write_enable_cmd, do_write_disable_cmd, do_status_write_cmd, do_prog, lvl_writable;
   assign is_write_enable_cmd = cmd_q == CMD_WRITE_ENABLE_CMD_C;
   assign is_write_disable_cmd = cmd_q == CMD_WRITE_DISABLE_CMD_C;
   assign is_status_write_cmd = cmd_q == CMD_STATUS_WRITE_CMD_C;
   assign is_page = cmd_q == CMD_PAGE_C;
   assign is_wipe = cmd_q == CMD_SECT_C || cmd_q == CMD_B32_C ||
                    cmd_q == CMD_B64_C;
   assign is_chip = cmd_q == CMD_CE1_C || cmd_q == CMD_CE2_C;
   assign is_dp = cmd_q == CMD_DP_C;
   assign is_rdp = cmd_q == CMD_RDP_C;
   // commands ignored in power-down except release
   assign ended = frame_end & byte_ok & (bitcnt_q >= BITS_CMD) &
                  (~dp_q | is_rdp);
   // status-write gating by lock select and protect pin
   assign sr_wr_allowed = wel_q & (~lock_sel_q | wp_s_q[1]);
   // level write only outside hardware-protected mode
   assign lvl_writable = ~(lock_sel_q & ~wp_s_q[1]);
   assign prot_hit = in_prot(lvl_q, cmp_q, addr_q);
   // chip erase permitted combinations
   assign chip_ok = (lvl_q == LVL_NONE && !cmp_q) ||
                    (lvl_q == LVL_ALL && cmp_q);
   assign do_write_enable_cmd = ended & is_write_enable_cmd & ~busy_q;
   assign do_write_disable_cmd = ended & is_write_disable_cmd & ~busy_q;
   assign do_status_write_cmd = ended & is_status_write_cmd & ~busy_q & sr_wr_allowed &
                    (bitcnt_q == BITS_STAT);
   // refused operations never start busy
   assign do_prog = ended & ~busy_q & wel_q & (
                    (is_page & (bitcnt_q > BITS_ADDR) & ~prot_hit) |
                    (is_wipe & (bitcnt_q == BITS_ADDR) & ~prot_hit) |
                    (is_chip & (bitcnt_q == BITS_CMD) & chip_ok));

   //----------------------------------------
   // status update
   //----------------------------------------
   logic busy_done;
   assign busy_done = busy_q & (busy_cnt_q == 16'h0000);
   // latch, busy and non-volatile bits
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wel_q <= 1'b0;
         busy_q <= 1'b0;
         busy_cnt_q <= 16'h0000;
         lock_sel_q <= STATUS_RST[SB_LOCKSEL];
         sec_q <= STATUS_RST[SB_SEC];
         cmp_q <= STATUS_RST[SB_CMP];
         lvl_q <= STATUS_RST[SB_LVL_HI:SB_LVL_LO];
         dp_q <= 1'b0;
      end else begin
         if (do_write_enable_cmd) wel_q <= 1'b1;
         else if (do_write_disable_cmd || busy_done) wel_q <= 1'b0;
         if (do_status_write_cmd || do_prog) begin
            busy_q <= 1'b1;
            busy_cnt_q <= BUSY_CYC;
         end else if (busy_done) busy_q <= 1'b0;
         else if (busy_q) busy_cnt_q <= busy_cnt_q - 16'h0001;
         if (do_status_write_cmd) begin
            if (lvl_writable) begin
               lvl_q <= sr_data_q[SB_LVL_HI:SB_LVL_LO];
               lock_sel_q <= sr_data_q[SB_LOCKSEL];
            end
            cmp_q <= sr_data_q[SB_CMP];
            sec_q <= sec_q | sr_data_q[SB_SEC];
         end
         if (ended && is_dp && !busy_q) dp_q <= 1'b1;
         else if (ended && is_rdp) dp_q <= 1'b0;
      end
   end

   //----------------------------------------
   // read status output and operation strobe
   //----------------------------------------
   logic [7:0] so_sh_q;
   logic so_q, oe_n_q, start_q;
   logic [1:0] kind_q;
   logic [23:0] oaddr_q;
   // status shifted out on falling edges after the read-status opcode
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         so_sh_q <= 8'h00;
         so_q <= 1'b0;
         oe_n_q <= 1'b1;
         start_q <= 1'b0;
         kind_q <= 2'h0;
         oaddr_q <= 24'h000000;
      end else begin
         start_q <= do_prog;
         if (do_prog) begin
            kind_q <= is_page ? 2'h1 : (is_wipe ? 2'h2 : 2'h3);
            oaddr_q <= addr_q;
         end
         if (cs_n_s) oe_n_q <= 1'b1;
         else if (sclk_fall && !dp_q && bitcnt_q >= BITS_CMD &&
                  cmd_q == CMD_RDSR_C) begin
            oe_n_q <= 1'b0;
            if (bitcnt_q[2:0] == 3'h0) begin
               so_q <= status[7];
               so_sh_q <= {status[6:0], 1'b0};
            end else begin
               so_q <= so_sh_q[7];
               so_sh_q <= {so_sh_q[6:0], 1'b0};
            end
         end
      end
   end
   assign spi_so = so_q;
   assign spi_so_oe_n = oe_n_q;
   assign status_out = status;
   assign deep_pd = dp_q;
   assign op_start = start_q;
   assign op_kind = kind_q;
   assign op_addr = oaddr_q;

   //----------------------------------------
   // assertions
   //----------------------------------------
   AST_WEL_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
      do_write_enable_cmd |=> wel_q)
      else $error("latch not set by write enable");
   AST_WEL_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (do_write_disable_cmd || busy_done) && !do_write_enable_cmd |=> !wel_q)
      else $error("latch not cleared");
   AST_DP_IGN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      dp_q && !is_rdp |-> !do_write_enable_cmd && !do_status_write_cmd && !do_prog)
      else $error("command obeyed in power-down");
   AST_BUSY_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(busy_q) |-> busy_q[*8])
      else $error("busy too short");
   AST_NOWEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !wel_q |-> !do_status_write_cmd && !do_prog)
      else $error("write accepted with latch clear");
   AST_LVL_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !do_status_write_cmd |=> $stable(lvl_q))
      else $error("level changed without status write");
   AST_PROT: assert property (@(posedge sys_clk) disable iff (!rst_n)
      do_prog && !is_chip |-> !prot_hit)
      else $error("protected area written");
   AST_CHIP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      do_prog && is_chip |-> chip_ok)
      else $error("chip erase not permitted");
   AST_HWLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
      lock_sel_q && !wp_s_q[1] |-> !do_status_write_cmd)
      else $error("status write in hardware lock");
   AST_SEC_OTP: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sec_q |=> sec_q)
      else $error("security lock cleared");
   AST_WRITE_DISABLE_CMD_BUSY: assert property (@(posedge sys_clk) disable iff (!rst_n)
      busy_q && wel_q && !busy_done |=> wel_q)
      else $error("latch cleared while busy");
   AST_ALIGN: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frame_end && !byte_ok |=> !busy_q || $past(busy_q))
      else $error("unaligned frame started work");
   CV_WRITE_ENABLE_CMD: cover property (@(posedge sys_clk) disable iff (!rst_n)
      do_write_enable_cmd);
   CV_STATUS_WRITE_CMD: cover property (@(posedge sys_clk) disable iff (!rst_n)
      do_status_write_cmd);
   CV_PROG: cover property (@(posedge sys_clk) disable iff (!rst_n)
      do_prog && is_page);
   CV_DP: cover property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(dp_q));
endmodule
`default_nettype wire

// ---- tb/sfwp_spi_host.sv ----
`default_nettype none
// ----------------------------------------
// spi host driving framed commands
// ----------------------------------------
module sfwp_spi_host (
   input wire logic sys_clk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_si
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle: clock parked low, deselected
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
   end
   // half a link period, four system clocks
   task automatic half();
      repeat (4) @(posedge sys_clk);
   endtask
   // one frame, msb first, whole bits only
   task automatic send(input logic [39:0] v, input int n);
      @(posedge sys_clk);
      spi_cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         spi_si <= v[i];
         half();
         spi_sclk <= 1'b1;
         half();
         spi_sclk <= 1'b0;
      end
      half();
      spi_cs_n <= 1'b1;
      spi_si <= ~spi_si; // released line does not hold its value
      half();
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_serial_flash_write_protect_status.sv ----
`default_nettype none
// ----------------------------------------
// bench for write protection and status
// ----------------------------------------
module tb_serial_flash_write_protect_status;
   import sfwp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] BUSY_T = 16'h0060;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic wp_n = 1'b1;
   logic spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe_n, deep_pd, op_start;
   logic [7:0] status_out;
   logic [1:0] op_kind;
   logic [23:0] op_addr, a;
   logic [7:0] exp_st = 8'h00;
   logic [25:0] op_q[$];
   logic [25:0] note;
   logic [31:0] rnd = 32'h0000C22F;
   logic [7:0] wipes[3] = '{CMD_SECT_C, CMD_B32_C, CMD_B64_C};
   logic [23:0] bnd[1:6] = '{24'h0FE000, 24'h0F8000 | 24'h004000,
      24'h0F8000, 24'h0F0000, 24'h0E0000, 24'h0C0000};
   int bad_count = 0;
   int cmp_count = 0;
   logic ok;
   logic [7:0] so_cap = 8'h00;

   // read-status data taken on link rising edges while driven
   always @(posedge spi_sclk) begin
      if (spi_so_oe_n === 1'b0)
         so_cap <= {so_cap[6:0], spi_so};
   end

   always #10 sys_clk = ~sys_clk;

   sfwp_core #(.BUSY_CYC(BUSY_T)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .wp_n(wp_n), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n),
      .status_out(status_out), .deep_pd(deep_pd), .op_start(op_start),
      .op_kind(op_kind), .op_addr(op_addr));
   sfwp_spi_host host_u (.sys_clk(sys_clk), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_si(spi_si));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // protected-region decode from level, complement and address
   function automatic logic prot(input logic c, input logic [2:0] l,
                                 input logic [23:0] x);
      if (l == 3'h0 || l == 3'h7)
         return (l == 3'h7) ^ c;
      return (x < bnd[l]) ^ c;
   endfunction
   task automatic check(input string what, input logic [23:0] exp,
                        input logic [23:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmd(input logic [39:0] v, input int n);
      host_u.send(v, n);
      repeat (6) @(negedge sys_clk);
   endtask
   task automatic st(input logic [7:0] e);
      check("status", {16'h0, e}, {16'h0, status_out});
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 2000 && status_out[0] !== 1'b0; i++)
         @(negedge sys_clk);
      check("busy", 24'h0, {23'h0, status_out[0]});
   endtask
   // status write, then latch cleared for the next step
   task automatic wsr(input logic [7:0] v, input logic [7:0] e);
      cmd(CMD_WRITE_ENABLE_CMD_C, 8);
      cmd({CMD_STATUS_WRITE_CMD_C, v}, 16);
      wait_idle();
      st(e);
      cmd(CMD_WRITE_DISABLE_CMD_C, 8);
      exp_st = e & 8'hFC;
   endtask
   // program or erase, expected started only when ok
   task automatic wr_op(input logic [39:0] v, input int n,
                        input logic [25:0] nt, input logic k);
      if (k)
         op_q.push_back(nt);
      cmd(CMD_WRITE_ENABLE_CMD_C, 8);
      cmd(v, n);
      if (k)
         check("busy", 24'h1, {23'h0, status_out[0]});
      wait_idle();
      st(exp_st | {6'h0, ~k, 1'b0});
      cmd(CMD_WRITE_DISABLE_CMD_C, 8);
      st(exp_st);
   endtask

   // result watcher: each started operation takes the oldest note
   always @(posedge sys_clk) begin
      if (op_start === 1'b1) begin
         if (op_q.size() == 0)
            check("op_start", 24'h0, 24'h1);
         else begin
            note = op_q.pop_front();
            check("op_kind", {22'h0, note[25:24]}, {22'h0, op_kind});
            if (note[25:24] != 2'd3)
               check("op_addr", note[23:0], op_addr);
         end
      end
   end

   // watchdog sized well above the expected run
   initial begin
      #1500000;
      bad_count++;
      report_and_stop();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (8) @(negedge sys_clk);
      st(8'h00);
      check("so_oe_n", 24'h1, {23'h0, spi_so_oe_n});
      cmd({CMD_STATUS_WRITE_CMD_C, 8'h1C}, 16);
      cmd({CMD_SECT_C, 24'h001000}, 32);
      st(8'h00);
      cmd({CMD_WRITE_ENABLE_CMD_C, 1'b0}, 9);
      st(8'h00);
      cmd(CMD_WRITE_ENABLE_CMD_C, 8);
      st(8'h02);
      cmd({CMD_RDSR_C, 8'h00}, 16);
      check("so", 24'h02, {16'h0, so_cap});
      check("so_oe_n", 24'h1, {23'h0, spi_so_oe_n});
      cmd({CMD_STATUS_WRITE_CMD_C, 7'h0E}, 15);
      st(8'h02);
      cmd(CMD_WRITE_DISABLE_CMD_C, 8);
      st(8'h00);
      cmd(CMD_DP_C, 8);
      check("deep_pd", 24'h1, {23'h0, deep_pd});
      cmd(CMD_WRITE_ENABLE_CMD_C, 8);
      st(8'h00);
      cmd(CMD_RDP_C, 8);
      check("deep_pd", 24'h0, {23'h0, deep_pd});
      op_q.push_back({2'd2, 24'h002000});
      cmd(CMD_WRITE_ENABLE_CMD_C, 8);
      cmd({CMD_SECT_C, 24'h002000}, 32);
      cmd(CMD_WRITE_DISABLE_CMD_C, 8);
      st(8'h03);
      wait_idle();
      st(8'h00);
      wr_op({CMD_PAGE_C, 24'h0ABC00, 8'hA5}, 40, {2'd1, 24'h0ABC00}, 1'b1);
      for (int c = 0; c < 16; c++) begin
         wsr({2'b00, c[3:0], 2'b00}, {2'b00, c[3:0], 2'b00});
         for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            a = (k == 2 || c[2:0] == 3'h0 || c[2:0] == 3'h7) ?
               {4'h0, rnd[19:0]} : bnd[c[2:0]] - 24'(k);
            ok = ~prot(c[3], c[2:0], a);
            wr_op({wipes[k], a}, 32, {2'd2, a}, ok);
         end
         ok = (c[3:0] == 4'h0) || (c[3:0] == 4'hF);
         wr_op(c[0] ? CMD_CE1_C : CMD_CE2_C, 8, {2'd3, 24'h0}, ok);
      end
      wsr(8'h80, 8'h80);
      @(posedge sys_clk);
      wp_n <= 1'b0;
      wsr(8'h9C, 8'h82);
      @(posedge sys_clk);
      wp_n <= 1'b1;
      wsr(8'h00, 8'h00);
      @(posedge sys_clk);
      wp_n <= 1'b0;
      wsr(8'h14, 8'h14);
      wsr(8'h40, 8'h40);
      wsr(8'h00, 8'h40);
      report_and_stop();
   end
endmodule
`default_nettype wire
